// ==== testbench/rx_client_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// client sink: collects whole packets
// ----------------------------------------
module rx_client_sink (
    input wire logic       clk,
    input wire logic [7:0] client_data,
    input wire logic       client_valid,
    input wire logic       client_packet_start,
    input wire logic       client_packet_end,
    input wire logic       client_gap,
    input wire logic [5:0] client_error_vector,
    input wire logic       client_checksum_fault,
    input wire logic       client_checksum_result_valid,
    input wire logic [2:0] client_ctrl_flag,
    input wire logic       pause_received
);
    logic [7:0] cur_q[$];
    logic [7:0] pkt_q[$];
    logic [5:0] err;
    logic [2:0] flag;
    logic       flt;
    logic       fv;
    int         pkt_cnt = 0;
    int         pause_cnt = 0;
    int         gap_cnt = 0;
    // a packet is handed on only at its end, so a dropped one leaves no trace
    always @(posedge clk) begin
        if (client_valid && client_packet_start)
            cur_q = {};
        if (client_valid)
            cur_q.push_back(client_data);
        // error vector sampled at end only
        if (client_valid && client_packet_end) begin
            pkt_q = cur_q;
            err = client_error_vector;
            flt = client_checksum_fault;
            fv = client_checksum_result_valid;
            flag = client_ctrl_flag;
            pkt_cnt++;
        end
        if (pause_received)
            pause_cnt++;
        if (client_gap)
            gap_cnt++;
    end
endmodule
`default_nettype wire

// ==== testbench/rx_mac_frame_checker_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_mac_frame_checker_tb;
    logic        clk = 0;
    logic        arst_n = 0;
    logic        ce = 1;
    logic [7:0]  link_char = 8'h07;
    logic        link_is_ctrl = 1;
    logic [15:0] reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic [31:0] reg_rdata;
    logic [7:0]  c_data;
    logic [5:0]  c_err;
    logic [2:0]  c_flag;
    logic        c_valid, c_start, c_end, c_gap, c_flt, c_fv, c_pause;
    logic [7:0]  frm[$];
    logic [31:0] fcs_g;
    int          seed = 32'hB546;
    int          fail_count = 0;
    int          checks_done = 0;
    int          n0 = 0;
    int          p0;

    always #20 clk = ~clk;

    rx_mac_frame_checker dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .link_char(link_char),
        .link_is_ctrl(link_is_ctrl), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .client_data(c_data), .client_valid(c_valid),
        .client_packet_start(c_start), .client_packet_end(c_end), .client_gap(c_gap),
        .client_error_vector(c_err), .client_checksum_fault(c_flt),
        .client_checksum_result_valid(c_fv), .client_ctrl_flag(c_flag), .pause_received(c_pause));

    rx_client_sink sink_u (.clk(clk), .client_data(c_data), .client_valid(c_valid),
        .client_packet_start(c_start), .client_packet_end(c_end), .client_gap(c_gap),
        .client_error_vector(c_err), .client_checksum_fault(c_flt),
        .client_checksum_result_valid(c_fv), .client_ctrl_flag(c_flag), .pause_received(c_pause));

    // reflected checksum over the frame body, complemented as sent
    function automatic logic [31:0] crc_of();
        logic [31:0] c;
        c = 32'hFFFF_FFFF;
        foreach (frm[i]) begin
            c = c ^ {24'h0, frm[i]};
            for (int b = 0; b < 8; b++)
                c = c[0] ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
        end
        return ~c;
    endfunction

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic put(input logic [7:0] c, input logic k);
        @(posedge clk);
        link_char <= c;
        link_is_ctrl <= k;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask

    task automatic mk_data(input int len);
        frm = {};
        repeat (len) frm.push_back(8'($random(seed)));
        frm[12] = 8'h00;
    endtask

    // a stray terminate follows every end and must be ignored
    task automatic send(input logic [7:0] st, input logic [7:0] sfd, input logic [7:0] pre,
                        input logic [7:0] endc, input logic bad);
        fcs_g = crc_of() ^ {31'h0, bad};
        put(st, 1'b1);
        repeat (6) put(pre, 1'b0);
        put(sfd, 1'b0);
        foreach (frm[i]) put(frm[i], 1'b0);
        for (int i = 0; i < 4; i++) put(fcs_g[8*i +: 8], 1'b0);
        put(endc, 1'b1);
        put(8'hFD, 1'b1);
        repeat (32) put(8'h07, 1'b1);
    endtask

    task automatic expect_pkt(input int add, input logic full, input logic [5:0] err, input logic [2:0] flag);
        check("packets", sink_u.pkt_cnt, n0 + add);
        n0 = sink_u.pkt_cnt;
        if (add == 0)
            return;
        if (full)
            frm = {frm, fcs_g[7:0], fcs_g[15:8], fcs_g[23:16], fcs_g[31:24]};
        check("length", sink_u.pkt_q.size(), frm.size());
        foreach (frm[i])
            if (i < sink_u.pkt_q.size())
                check("byte", {24'h0, sink_u.pkt_q[i]}, {24'h0, frm[i]});
        check("error vector", {26'h0, sink_u.err}, {26'h0, err});
        check("fault", {31'h0, sink_u.flt}, {31'h0, err[1]});
        check("result valid", {31'h0, sink_u.fv}, 32'h1);
        check("ctrl flag", {29'h0, sink_u.flag}, {29'h0, flag});
    endtask

    task automatic ctl_case(input logic [7:0] op_hi, input logic [7:0] op_lo, input int add,
                            input logic [2:0] flag, input int acts);
        mk_data(60);
        frm[12] = 8'h88;
        frm[13] = 8'h08;
        frm[14] = op_hi;
        frm[15] = op_lo;
        p0 = sink_u.pause_cnt;
        send(8'hFB, 8'hD5, 8'h55, 8'hFD, 1'b0);
        expect_pkt(add, 1'b0, 6'h00, flag);
        check("pause acted", sink_u.pause_cnt, p0 + acts);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(16'h050A, 32'h0, "rx ctrl reset");
        rd(16'h050C, 32'h1, "crc cfg reset");
        rd(16'h050D, 32'h0, "pause fwd reset");
        rd(16'h050E, 32'h0000_FF01, "pause en reset");
        rd(16'h0600, 32'h0, "unmapped");
        wr(16'h050A, 32'hFFFF_FFFF);
        rd(16'h050A, 32'h18, "rx ctrl mask");
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr(16'h050D, 32'h1);
        ce <= 1'b1;
        rd(16'h050D, 32'h0, "ce freeze");
        // random frames, removal toggled, some with a bad checksum
        for (int i = 0; i < 8; i++) begin
            wr(16'h050C, {31'h0, i[0]});
            mk_data(16 + ($random(seed) & 31));
            send(8'hFB, 8'hD5, 8'h55, 8'hFD, i[2]);
            expect_pkt(1, !i[0], {4'h0, i[2], 1'b0}, 3'h0);
        end
        // every strict check setting against a bad preamble and a bad SFD
        for (int j = 0; j < 8; j++) begin
            wr(16'h050A, {27'h0, j[1:0], 3'h0});
            mk_data(24);
            send(8'hFB, j[2] ? 8'hD4 : 8'hD5, j[2] ? 8'h55 : 8'h54, 8'hFD, 1'b0);
            expect_pkt((j[2] ? j[0] : j[1]) ? 0 : 1, 1'b0, 6'h00, 3'h0);
        end
        wr(16'h050A, 32'h0);
        send(8'hFC, 8'hD5, 8'h55, 8'hFD, 1'b0);
        expect_pkt(0, 1'b0, 6'h00, 3'h0);
        send(8'hFB, 8'hD5, 8'h55, 8'hFE, 1'b0);
        expect_pkt(1, 1'b0, 6'h03, 3'h0);
        send(8'hFB, 8'hD5, 8'h55, 8'h07, 1'b0);
        expect_pkt(1, 1'b0, 6'h03, 3'h0);
        ctl_case(8'h00, 8'h01, 0, 3'h1, 1);
        ctl_case(8'h01, 8'h01, 1, 3'h2, 0);
        ctl_case(8'h00, 8'h02, 1, 3'h4, 0);
        wr(16'h050D, 32'h1);
        ctl_case(8'h00, 8'h01, 1, 3'h1, 1);
        wr(16'h050E, 32'h0);
        ctl_case(8'h00, 8'h01, 1, 3'h1, 0);
        // 19 frame ends so far, 6 of them with a bad checksum or malformed
        rd(16'h050F, 32'h0006_0013, "status");
        check("gap octets", sink_u.gap_cnt, 0);
        stop_test();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire

// ==== verilog/rx_crc32_step.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rx_mac_cfg.svh"

// ----------------------------------------
// one byte step of the frame checksum
// ----------------------------------------
module rx_crc32_step (
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_in,
    output logic      [31:0] crc_out
);
    logic [31:0] acc;

    // lsb first order
    // bits enter least significant first, so the x31 term
    // is bit 0 of the first checksum byte
    always_comb begin
        acc = crc_in;
        for (int b = 0; b < 8; b++) begin
            acc = {1'b0, acc[31:1]} ^
                  ((acc[0] ^ data_in[b]) ? `CRC_POLY : 32'h0000_0000);
        end
        crc_out = acc;
    end
endmodule
`default_nettype wire

// ==== verilog/rx_mac_cfg.svh ====
`ifndef RX_MAC_CFG_SVH
`define RX_MAC_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_RX_CTRL   16'h050A
`define OFS_CRC_CFG   16'h050C
`define OFS_PAUSE_FWD 16'h050D
`define OFS_PAUSE_EN  16'h050E
`define OFS_STATUS    16'h050F

// ----------------------------------------
// field positions and writable masks
// ----------------------------------------
`define BIT_PRE_CHK  4
`define BIT_SFD_CHK  3
`define BIT_CRC_RM   0
`define BIT_FWD      0
`define BIT_STD_EN   0
`define PFC_EN_LSB   8
`define PFC_EN_MSB   15
`define MSK_RX_CTRL  32'h0000_0018
`define MSK_CRC_CFG  32'h0000_0001
`define MSK_FWD      32'h0000_0001
`define MSK_PAUSE_EN 32'h0000_FF01

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_RX_CTRL   32'h0000_0000
`define RST_CRC_CFG   32'h0000_0001
`define RST_FWD       32'h0000_0000
`define RST_PAUSE_EN  32'h0000_FF01

// ----------------------------------------
// link characters and frame layout
// ----------------------------------------
`define CH_START     8'hFB
`define CH_TERM      8'hFD
`define CH_ERR       8'hFE
`define CH_PRE       8'h55
`define CH_SFD       8'hD5
`define PRE_LAST     3'h5
`define PRE_SEQ_LEN  8
`define LINE_BASE    20
`define FCS_MARK     5
`define IDX_TY_HI    5'h0C
`define IDX_TY_LO    5'h0D
`define IDX_OP_HI    5'h0E
`define IDX_OP_LO    5'h0F
`define TYPE_HI      8'h88
`define TYPE_LO      8'h08
`define OP_STD_HI    8'h00
`define OP_PFC_HI    8'h01
`define OP_LO        8'h01
`define CTL_NONE     3'h0
`define CTL_STD      3'h1
`define CTL_PFC      3'h2
`define CTL_OTHER    3'h4

// ----------------------------------------
// checksum
// ----------------------------------------
`define CRC_POLY     32'hEDB8_8320
`define CRC_INIT     32'hFFFF_FFFF
`define CRC_RESIDUE  32'hDEBB_20E3

`endif

// ==== verilog/rx_mac_frame_checker.sv ====
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rx_mac_cfg.svh"

module rx_mac_frame_checker
    import rx_mac_pkg::*;
#(
    parameter bit         STRICT_CHECK  = 1'b1,
    parameter bit         PREAMBLE_PASS = 1'b0,
    parameter bit         EOP_ALIGN     = 1'b1,
    parameter bit         NARROW_IF     = 1'b0,
    parameter flow_mode_t FLOW_MODE     = FLOW_STD
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  link_char,
    input  wire logic        link_is_ctrl,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [7:0]  client_data,
    output logic             client_valid,
    output logic             client_packet_start,
    output logic             client_packet_end,
    output logic             client_gap,
    output logic      [5:0]  client_error_vector,
    output logic             client_checksum_fault,
    output logic             client_checksum_result_valid,
    output logic      [2:0]  client_ctrl_flag,
    output logic             pause_received
);
    localparam int DEPTH = `LINE_BASE + (PREAMBLE_PASS ? `PRE_SEQ_LEN : 0);

    logic [31:0] receive_mac_control;
    logic [31:0] checksum_config_register;
    logic [31:0] pause_forward;
    logic [31:0] pause_rx_enable;
    logic [15:0] pkt_cnt;
    logic [15:0] err_cnt;
    rx_state_t   st;
    rx_state_t   next_st;
    logic [2:0]  pre_cnt;
    logic [4:0]  idx;
    logic [31:0] crc;
    logic [31:0] crc_next;
    logic        drop_frame;
    logic        ty_hi;
    logic        ty_ok;
    logic        op_std;
    logic        op_pfc;
    logic [2:0]  ctl_class;
    logic        act_ok;
    tok_t        line [DEPTH];
    tok_t        nxt  [DEPTH];
    tok_t        in_tok;
    tok_t        tail;
    logic        out_pass;
    logic        mute;
    logic        f_q;
    logic        v_q;
    logic        f_qq;
    logic        v_qq;

    // ----------------------------------------
    // register port
    // ----------------------------------------
    wire hit_ctrl = reg_addr == `OFS_RX_CTRL;
    wire hit_crc  = reg_addr == `OFS_CRC_CFG;
    wire hit_fwd  = reg_addr == `OFS_PAUSE_FWD;
    wire hit_pen  = reg_addr == `OFS_PAUSE_EN;
    wire hit_stat = reg_addr == `OFS_STATUS;

    // unmapped addresses read as zero
    wire [31:0] rd_mux = hit_ctrl ? receive_mac_control :
                         hit_crc  ? checksum_config_register :
                         hit_fwd  ? pause_forward :
                         hit_pen  ? pause_rx_enable :
                         hit_stat ? {err_cnt, pkt_cnt} : 32'h0000_0000;

    // software writes; reserved bits are masked so they read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            receive_mac_control      <= `RST_RX_CTRL;
            checksum_config_register <= `RST_CRC_CFG;
            pause_forward            <= `RST_FWD;
            pause_rx_enable          <= `RST_PAUSE_EN;
            reg_rdata                <= 32'h0000_0000;
        end else if (ce) begin
            if (reg_wr && hit_ctrl) receive_mac_control <= reg_wdata & `MSK_RX_CTRL;
            if (reg_wr && hit_crc) checksum_config_register <= reg_wdata & `MSK_CRC_CFG;
            if (reg_wr && hit_fwd) pause_forward <= reg_wdata & `MSK_FWD;
            if (reg_wr && hit_pen) pause_rx_enable <= reg_wdata & `MSK_PAUSE_EN;
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // strict check enables
    // the bits only matter when strict checking is built in
    wire chk_pre = STRICT_CHECK && receive_mac_control[`BIT_PRE_CHK];
    wire chk_sfd = STRICT_CHECK && receive_mac_control[`BIT_SFD_CHK];
    wire crc_rm  = checksum_config_register[`BIT_CRC_RM];
    wire fwd     = pause_forward[`BIT_FWD];
    wire std_en  = pause_rx_enable[`BIT_STD_EN];
    wire pfc_en  = |pause_rx_enable[`PFC_EN_MSB:`PFC_EN_LSB];

    // ----------------------------------------
    // link side decode
    // ----------------------------------------
    wire in_idle   = st == ST_IDLE;
    wire in_pre    = st == ST_PRE;
    wire in_sfd    = st == ST_SFD;
    wire in_data   = st == ST_DATA;
    wire is_start  = link_is_ctrl && link_char == `CH_START;
    wire is_term   = link_is_ctrl && link_char == `CH_TERM;
    wire is_err    = link_is_ctrl && link_char == `CH_ERR;
    wire open_frm  = in_idle && is_start;
    // loose mode only rejects control characters here
    wire pre_bad   = link_is_ctrl || (chk_pre && link_char != `CH_PRE);
    wire sfd_bad   = link_is_ctrl || (chk_sfd && link_char != `CH_SFD);
    wire abandon   = (in_pre && pre_bad) || (in_sfd && sfd_bad);
    wire pre_ok    = (in_pre && !pre_bad) || (in_sfd && !sfd_bad);
    wire dat_byte  = in_data && !link_is_ctrl;
    wire frm_end   = in_data && link_is_ctrl;
    // any non-terminate control ends the frame malformed
    wire malformed = frm_end && !is_term;
    // error characters force a checksum fault too
    wire fcs_bad   = malformed || crc != `CRC_RESIDUE;
    wire long_frm  = PREAMBLE_PASS || idx >= 5'(`FCS_MARK);
    wire is_std    = ty_ok && op_std && link_char == `OP_LO;
    wire is_pfc    = ty_ok && op_pfc && link_char == `OP_LO;
    // only the configured pause kind is filtered
    wire mode_hit  = (FLOW_MODE == FLOW_STD && is_std) ||
                     (FLOW_MODE == FLOW_PFC && is_pfc);

    rx_crc32_step u_crc (
        .crc_in  (crc),
        .data_in (link_char),
        .crc_out (crc_next)
    );

    // start, six preamble bytes, sfd, data
    always_comb begin
        case (st)
            ST_IDLE: next_st = is_start ? ST_PRE : ST_IDLE;
            ST_PRE:  next_st = pre_bad ? ST_IDLE :
                               (pre_cnt == `PRE_LAST) ? ST_SFD : ST_PRE;
            ST_SFD:  next_st = sfd_bad ? ST_IDLE : ST_DATA;
            ST_DATA: next_st = link_is_ctrl ? ST_IDLE : ST_DATA;
            default: next_st = ST_IDLE;
        endcase
    end

    // state, preamble count and checksum
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st      <= ST_IDLE;
            pre_cnt <= 3'h0;
            crc     <= `CRC_INIT;
        end else if (ce) begin
            st      <= next_st;
            pre_cnt <= in_pre ? pre_cnt + 3'h1 : 3'h0;
            if (open_frm) crc <= `CRC_INIT;
            else if (dat_byte) crc <= crc_next;
        end
    end

    // header parse: type and opcode decide the control class
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idx       <= 5'h00;
            ty_hi     <= 1'b0;
            ty_ok     <= 1'b0;
            op_std    <= 1'b0;
            op_pfc    <= 1'b0;
            ctl_class <= `CTL_NONE;
            act_ok    <= 1'b0;
        end else if (ce) begin
            if (open_frm) begin
                idx       <= 5'h00;
                ty_ok     <= 1'b0;
                ctl_class <= `CTL_NONE;
                act_ok    <= 1'b0;
            end else if (dat_byte) begin
                if (idx != 5'h1F) idx <= idx + 5'h01;
                if (idx == `IDX_TY_HI) ty_hi <= link_char == `TYPE_HI;
                if (idx == `IDX_TY_LO) ty_ok <= ty_hi && link_char == `TYPE_LO;
                if (idx == `IDX_OP_HI) op_std <= link_char == `OP_STD_HI;
                if (idx == `IDX_OP_HI) op_pfc <= link_char == `OP_PFC_HI;
                if (idx == `IDX_OP_LO) ctl_class <= !ty_ok ? `CTL_NONE :
                                                    is_std ? `CTL_STD :
                                                    is_pfc ? `CTL_PFC : `CTL_OTHER;
                if (idx == `IDX_OP_LO) act_ok <= mode_hit &&
                                                 (is_std ? std_en : pfc_en);
            end
        end
    end

    // drop decision, pause action and counters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drop_frame     <= 1'b0;
            pause_received <= 1'b0;
            pkt_cnt        <= 16'h0000;
            err_cnt        <= 16'h0000;
        end else if (ce) begin
            // a failed strict check hides the frame
            if (open_frm) drop_frame <= 1'b0;
            else if (abandon) drop_frame <= 1'b1;
            // matching pause frames dropped unless forwarded
            else if (dat_byte && idx == `IDX_OP_LO && mode_hit && !fwd) drop_frame <= 1'b1;
            // no flow mode never sets act_ok
            pause_received <= frm_end && !fcs_bad && act_ok;
            if (frm_end) pkt_cnt <= pkt_cnt + 16'h0001;
            if (frm_end && fcs_bad) err_cnt <= err_cnt + 16'h0001;
        end
    end

    // ----------------------------------------
    // fixed latency line
    // ----------------------------------------
    // a slot per cycle gives the header time to be classified
    // before the first byte leaves, at the cost of DEPTH cycles
    always_comb begin
        in_tok      = '0;
        in_tok.data = link_char;
        // preamble slots only enter with pass-through
        if (open_frm) begin
            in_tok.valid = PREAMBLE_PASS;
            in_tok.sop   = 1'b1;
        end else if (in_idle) begin
            // gap octets only reach the narrow interface
            in_tok.valid = NARROW_IF;
            in_tok.gap   = 1'b1;
        end else if (pre_ok) begin
            in_tok.valid = PREAMBLE_PASS;
        end else if (dat_byte) begin
            in_tok.valid = 1'b1;
            in_tok.sop   = !PREAMBLE_PASS && idx == 5'h00;
        end
    end

    assign nxt[0] = in_tok;

    // end marks are written back into the slots already in flight
    for (genvar gi = 1; gi < DEPTH; gi++) begin : g_line
        logic hit_last;
        logic hit_pl;
        // last fcs byte and last payload byte
        assign hit_last = gi == 1 && frm_end;
        assign hit_pl   = frm_end && (long_frm ? gi == `FCS_MARK : gi == 1);
        always_comb begin
            nxt[gi] = line[gi-1];
            // inserted errors arrive as error characters
            if (hit_last || hit_pl) begin
                nxt[gi].malf    = malformed;
                nxt[gi].fcs_err = fcs_bad;
            end
            if (hit_last) nxt[gi].eop_fcs = 1'b1;
            if (hit_pl) nxt[gi].eop_pl = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) line[i] <= '0;
        end else if (ce) begin
            line <= nxt;
        end
    end

    // ----------------------------------------
    // client side
    // ----------------------------------------
    assign tail = line[DEPTH-1];
    wire pass_now = tail.sop ? !drop_frame : out_pass;
    wire live     = tail.sop || !mute;
    wire emit     = tail.valid && (tail.gap || (pass_now && live));
    // removal picks the payload end mark
    wire eop_now  = !tail.gap && (crc_rm ? tail.eop_pl : tail.eop_fcs);
    wire end_now  = emit && eop_now;

    // every client output leaves a clk flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_pass            <= 1'b0;
            mute                <= 1'b1;
            client_ctrl_flag    <= `CTL_NONE;
            client_data         <= 8'h00;
            client_valid        <= 1'b0;
            client_packet_start <= 1'b0;
            client_packet_end   <= 1'b0;
            client_gap          <= 1'b0;
            client_error_vector <= 6'h00;
        end else if (ce) begin
            if (tail.valid && tail.sop) out_pass <= !drop_frame;
            if (tail.valid && tail.sop && !drop_frame) client_ctrl_flag <= ctl_class;
            // removed checksum bytes stay muted until the next start
            if (tail.valid && !tail.gap) mute <= (mute && !tail.sop) || eop_now;
            client_data         <= tail.data;
            client_valid        <= emit;
            client_packet_start <= emit && tail.sop;
            client_packet_end   <= end_now;
            client_gap          <= emit && tail.gap;
            // error vector only in end cycles
            client_error_vector <= end_now ? {4'h0, tail.fcs_err, tail.malf} : 6'h00;
        end
    end

    // fault aligned with end or one cycle after
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            f_q  <= 1'b0;
            v_q  <= 1'b0;
            f_qq <= 1'b0;
            v_qq <= 1'b0;
        end else if (ce) begin
            f_q  <= end_now && tail.fcs_err;
            v_q  <= end_now;
            f_qq <= f_q;
            v_qq <= v_q;
        end
    end

    // fault and result valid travel together
    assign client_checksum_fault        = EOP_ALIGN ? f_q : f_qq;
    assign client_checksum_result_valid = EOP_ALIGN ? v_q : v_qq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    start_gate_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && in_idle && !is_start |=> st == ST_IDLE
    ) else $error("frame opened without start byte");

    sfd_drop_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && in_sfd && chk_sfd && link_char != `CH_SFD |=> in_idle && drop_frame
    ) else $error("bad sfd not dropped");

    pre_drop_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && in_pre && chk_pre && link_char != `CH_PRE |=> drop_frame
    ) else $error("bad preamble not dropped");

    loose_sfd_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && in_sfd && !chk_sfd && !link_is_ctrl |=> st == ST_DATA
    ) else $error("loose mode refused sfd");

    malf_mark_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && frm_end && is_err |=> in_idle && line[1].malf && line[1].fcs_err && line[1].eop_fcs
    ) else $error("error character not marked");

    fault_pair_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        client_checksum_fault |-> client_checksum_result_valid
    ) else $error("fault without result valid");

    late_fault_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && client_packet_end && client_error_vector[1]
        |-> (if (EOP_ALIGN) client_checksum_fault else ##1 (!ce || client_checksum_fault))
    ) else $error("fault timing wrong");

    class_hot_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        $onehot0(client_ctrl_flag)
    ) else $error("control flag not one-hot");

    pause_drop_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && tail.valid && tail.sop && drop_frame |=> !client_packet_start
    ) else $error("dropped frame delivered");

    err_end_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        client_error_vector != 6'h00 |-> client_packet_end
    ) else $error("error vector outside end");

    gap_fwd_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        client_valid && client_gap |-> NARROW_IF
    ) else $error("gap octet forwarded");
endmodule
`default_nettype wire

// ==== verilog/rx_mac_pkg.sv ====
`default_nettype none
package rx_mac_pkg;

    // gray coded along idle, preamble, sfd, data
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE  = 2'b01,
        ST_SFD  = 2'b11,
        ST_DATA = 2'b10
    } rx_state_t;

    typedef enum logic [1:0] {
        FLOW_NONE = 2'b00,
        FLOW_STD  = 2'b01,
        FLOW_PFC  = 2'b10
    } flow_mode_t;

    // one byte slot of the fixed latency line
    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       gap;
        logic       eop_pl;
        logic       eop_fcs;
        logic       malf;
        logic       fcs_err;
        logic [7:0] data;
    } tok_t;

endpackage
`default_nettype wire
